// *** include/spfc_pkg.sv ***
// Purpose: constants and types for the sector flash program controller
// Assumes: 50 MHz core clock, 64K x 8 parallel flash on the far side
// Notes:   command words are data and address pairs in hexadecimal
package spfc_pkg;
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned SECTOR_BYTES = 128;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned SECTOR_LSB = 7;
	localparam int unsigned POLL_BIT = 7;
	localparam int unsigned TOGGLE_BIT = 6;
	// program_cycle_time in ms, byte_load_window in us
	localparam int unsigned PROGRAM_CYCLE_TIME_MS = 20;
	localparam int unsigned BYTE_LOAD_WINDOW_US = 150;
	localparam int unsigned PROGRAM_CYCLE_CYC =
		PROGRAM_CYCLE_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned BYTE_LOAD_WINDOW_CYC =
		BYTE_LOAD_WINDOW_US * CLK_MHZ;
	// strobe phase lengths: 200 ns low, 200 ns high, 120 ns access
	localparam int unsigned WP_NS = 200;
	localparam int unsigned WPH_NS = 200;
	localparam int unsigned ACC_NS = 120;
	localparam int unsigned CLK_NS = 20;
	localparam int unsigned WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS + 2;
	localparam logic [7:0] CMD_UNLOCK1_D = 8'h00_AA;
	localparam logic [15:0] CMD_UNLOCK1_A = 16'h0000_5555;
	localparam logic [7:0] CMD_UNLOCK2_D = 8'h00_55;
	localparam logic [15:0] CMD_UNLOCK2_A = 16'h0000_2AAA;
	localparam logic [7:0] CMD_PROT_D = 8'h00_A0;
	localparam logic [7:0] CMD_ID_ENTRY_D = 8'h00_90;
	localparam logic [7:0] CMD_ID_EXIT_D = 8'h00_F0;
	localparam logic [1:0] OP_PROGRAM = 2'h0_0;
	localparam logic [1:0] OP_ID_READ = 2'h0_1;
	localparam logic [1:0] OP_READ = 2'h0_2;
	typedef struct packed {
		logic       ce_n;
		logic       oe_n;
		logic       we_n;
		logic [15:0] addr;
		logic [7:0] dout;
		logic       doe;
	} spfc_pins_t;
	typedef struct packed {
		logic       valid;
		logic [1:0] op;
		logic [15:0] addr;
	} spfc_cmd_t;
endpackage : spfc_pkg

// *** core/spfc_ctrl.sv ***
// Purpose: host side controller that programs one flash sector, reads
//          identification codes and does plain reads
// Assumes: flash data pins sampled through two flops; one clock
// Notes:   sector data comes from the user one byte per request
// Operation
// RQ1: keep output gate high while writing
// RQ2: same sector address on every load
// RQ3: unloaded sector bytes end undefined
// RQ4: protection returns after each program cycle
// RQ5: always load all 128 sector bytes
// RQ6: program cycle ends within 20 ms
// RQ7: next load within 150 us window
// RQ8: poll toggle bit by toggling output gate
// RQ9: judge toggle bit only by change
// RQ10: poll at one fixed address
// RQ11: identification code chosen by addr_lsb
// RQ12: identification mode clears at power loss
// RQ13: exit command restores normal operation
// RQ14: command words are data and address hex
// RQ15: polled bit seven inverted while busy
// RQ16: toggle bit flips each busy read
// RQ17: protection sequence precedes every load; code sends it once per program, before the first of the 128 loads
`timescale 1ns/10ps
module spfc_ctrl
	import spfc_pkg::*;
#(
	parameter int unsigned PROG_TIMEOUT_CYC = PROGRAM_CYCLE_CYC,
	parameter int unsigned LOAD_WINDOW_CYC  = BYTE_LOAD_WINDOW_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire spfc_cmd_t   i_cmd,
	input  wire logic [7:0]  i_wdata,
	output logic             o_cmd_ready,
	output logic             o_wdata_req,
	output logic             o_done,
	output logic             o_timeout,
	output logic [7:0]       o_rdata,
	output logic             o_flash_ce_n,
	output logic             o_flash_oe_n,
	output logic             o_flash_we_n,
	output logic [15:0]      o_flash_addr,
	output logic [7:0]       o_flash_dq_o,
	output logic             o_flash_dq_oe,
	input  wire logic [7:0]  i_flash_dq_i
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_WR   = 6'b00_0010,
		ST_RD   = 6'b00_0100,
		ST_NEXT = 6'b00_1000,
		ST_POLL = 6'b01_0000,
		ST_END  = 6'b10_0000
	} spfc_state_t;

	spfc_state_t state;
	logic [7:0]  dq_meta;
	logic [7:0]  dq_sync;
	logic [1:0]  op;
	logic [15:0] base;
	logic [3:0]  step;
	logic [7:0]  count;
	logic [4:0]  phase;
	logic [7:0]  last_byte;
	logic [7:0]  prev_read;
	logic        have_prev;
	logic [31:0] timer;
	logic [7:0]  next_data;
	logic [15:0] next_addr;

	// pins come from outside the clock domain
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			dq_meta <= 8'h00_00;
			dq_sync <= 8'h00_00;
		end else begin
			dq_meta <= i_flash_dq_i;
			dq_sync <= dq_meta;
		end
	end

	// command word table for the current step
	always_comb begin
		next_data = CMD_UNLOCK1_D;
		next_addr = CMD_UNLOCK1_A;
		case (step)
			4'h0_0: begin
				next_data = CMD_UNLOCK1_D; // [RQ14]
				next_addr = CMD_UNLOCK1_A;
			end
			4'h0_1: begin
				next_data = CMD_UNLOCK2_D;
				next_addr = CMD_UNLOCK2_A;
			end
			default: begin
				next_addr = CMD_UNLOCK1_A;
				if (op == OP_PROGRAM) begin
					next_data = CMD_PROT_D; // [RQ17]
				end else if (count == 8'h00_00) begin
					next_data = CMD_ID_ENTRY_D;
				end else begin
					next_data = CMD_ID_EXIT_D; // [RQ13]
				end
				if (op == OP_PROGRAM && step >= 4'h0_3) begin
					next_data = i_wdata;
					// sector bits fixed from the base address [RQ2]
					next_addr = {base[15:SECTOR_LSB], count[6:0]};
				end
			end
		endcase
	end

	// sequencer and pin drive
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state         <= ST_IDLE;
			op            <= OP_READ;
			base          <= 16'h0000_0000;
			step          <= 4'h0_0;
			count         <= 8'h00_00;
			phase         <= 5'h0_0;
			last_byte     <= 8'h00_00;
			prev_read     <= 8'h00_00;
			have_prev     <= 1'b0;
			timer         <= 32'h0000_0000;
			o_cmd_ready   <= 1'b0;
			o_wdata_req   <= 1'b0;
			o_done        <= 1'b0;
			o_timeout     <= 1'b0;
			o_rdata       <= 8'h00_00;
			o_flash_ce_n  <= 1'b1;
			o_flash_oe_n  <= 1'b1;
			o_flash_we_n  <= 1'b1;
			o_flash_addr  <= 16'h0000_0000;
			o_flash_dq_o  <= 8'h00_00;
			o_flash_dq_oe <= 1'b0;
		end else begin
			o_done      <= 1'b0;
			o_wdata_req <= 1'b0;
			case (state)
				ST_IDLE: begin
					o_cmd_ready <= 1'b1;
					if (i_cmd.valid && o_cmd_ready) begin
						o_cmd_ready <= 1'b0;
						o_timeout   <= 1'b0;
						op          <= i_cmd.op;
						base        <= i_cmd.addr;
						step        <= 4'h0_0;
						count       <= 8'h00_00;
						phase       <= 5'h0_0;
						have_prev   <= 1'b0;
						state       <= (i_cmd.op == OP_READ) ? ST_RD : ST_WR;
					end
				end
				ST_WR: begin
					// output gate stays high through the write [RQ1]
					o_flash_oe_n  <= 1'b1;
					o_flash_addr  <= next_addr;
					o_flash_dq_o  <= next_data;
					o_flash_dq_oe <= 1'b1;
					phase         <= phase + 5'h0_1;
					if (phase == 5'h0_1) begin
						o_flash_ce_n <= 1'b0;
						o_flash_we_n <= 1'b0;
					end
					if (phase == 5'(1 + WP_CYC)) begin
						o_flash_ce_n <= 1'b1;
						o_flash_we_n <= 1'b1;
						if (op == OP_PROGRAM && step >= 4'h0_3) begin
							last_byte   <= next_data;
							o_wdata_req <= 1'b1;
						end
					end
					if (phase == 5'(1 + WP_CYC + WPH_CYC)) begin
						phase <= 5'h0_0;
						state <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					// loads follow back to back, well inside the window [RQ7]
					o_flash_dq_oe <= 1'b0;
					state         <= ST_WR;
					if (step < 4'h0_3) begin
						// hold at the data step so a long load cannot wrap
						step <= step + 4'h0_1;
					end
					if (op == OP_PROGRAM && step >= 4'h0_3) begin
						count <= count + 8'h00_01;
						// every byte of the sector is loaded [RQ5] [RQ3]
						if (count == 8'(SECTOR_BYTES - 1)) begin
							step  <= 4'h0_0;
							timer <= 32'h0000_0000;
							state <= ST_POLL;
						end
					end else if (op != OP_PROGRAM && step == 4'h0_2) begin
						if (count == 8'h00_00) begin
							// id mode: read code at addr_lsb [RQ11]
							base  <= {15'h0000, base[0]};
							state <= ST_RD;
						end else begin
							state <= ST_END;
						end
					end
				end
				ST_RD: begin
					o_flash_dq_oe <= 1'b0;
					o_flash_addr  <= base;
					o_flash_ce_n  <= 1'b0;
					o_flash_oe_n  <= 1'b0;
					phase         <= phase + 5'h0_1;
					if (phase == 5'(ACC_CYC)) begin
						o_rdata      <= dq_sync;
						o_flash_ce_n <= 1'b1;
						o_flash_oe_n <= 1'b1;
						phase        <= 5'h0_0;
						if (op == OP_ID_READ) begin
							// leave id mode again [RQ13]
							count <= 8'h00_01;
							step  <= 4'h0_0;
							state <= ST_WR;
						end else begin
							state <= ST_END;
						end
					end
				end
				ST_POLL: begin
					// fixed address, oe toggled per read [RQ8] [RQ10]
					// last loaded cell, so bit 7 is judged where it was written
					o_flash_addr <= {base[15:SECTOR_LSB], 7'(SECTOR_BYTES - 1)};
					timer        <= timer + 32'h0000_0001;
					phase        <= phase + 5'h0_1;
					if (phase == 5'h0_0) begin
						o_flash_ce_n <= 1'b0;
						o_flash_oe_n <= 1'b0;
					end
					if (phase == 5'(ACC_CYC)) begin
						o_flash_oe_n <= 1'b1;
						prev_read    <= dq_sync;
						have_prev    <= 1'b1;
						// done when toggle bit stops and bit 7 matches bit 7 of the last loaded byte
						// [RQ9] [RQ15] [RQ16]
						if (have_prev &&
						    dq_sync[TOGGLE_BIT] == prev_read[TOGGLE_BIT] &&
						    dq_sync[POLL_BIT] == last_byte[POLL_BIT]) begin
							o_flash_ce_n <= 1'b1;
							state        <= ST_END;
						end
					end
					if (phase == 5'(ACC_CYC + WPH_CYC)) begin
						phase <= 5'h0_0;
					end
					// give up past the program cycle time [RQ6]
					if (timer >= PROG_TIMEOUT_CYC) begin
						o_timeout    <= 1'b1;
						o_flash_ce_n <= 1'b1;
						o_flash_oe_n <= 1'b1;
						state        <= ST_END;
					end
				end
				ST_END: begin
					// protection is back; next program repeats unlock [RQ4]
					o_flash_ce_n  <= 1'b1;
					o_flash_oe_n  <= 1'b1;
					o_flash_dq_oe <= 1'b0;
					o_done        <= 1'b1;
					state         <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule : spfc_ctrl

// *** verification/spfc_ctrl_asserts.sv ***
// Purpose: pin protocol checks for the sector flash controller
// Assumes: one clock domain, asynchronous active high reset
// Notes:   bound to every spfc_ctrl instance
`timescale 1ns/10ps
module spfc_ctrl_asserts
	import spfc_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire spfc_cmd_t   i_cmd,
	input  wire logic        o_cmd_ready,
	input  wire logic        o_done,
	input  wire logic        o_flash_ce_n,
	input  wire logic        o_flash_oe_n,
	input  wire logic        o_flash_we_n,
	input  wire logic [15:0] o_flash_addr,
	input  wire logic [7:0]  o_flash_dq_o,
	input  wire logic        o_flash_dq_oe
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	sequence s_wr;
		!o_flash_we_n && !o_flash_ce_n;
	endsequence
	sequence s_wr_held;
		!o_flash_we_n && !$past(o_flash_we_n);
	endsequence
	sequence s_rd_held;
		!o_flash_oe_n && !$past(o_flash_oe_n);
	endsequence
	AST_OE_HIGH_WR: assert property (s_wr |-> o_flash_oe_n)
		else $error("output gate low during a write");
	AST_NO_FIGHT: assert property (!o_flash_oe_n |-> !o_flash_dq_oe)
		else $error("data driven while the flash drives");
	AST_DQ_DRIVEN: assert property (s_wr |-> o_flash_dq_oe)
		else $error("data not driven during a write");
	AST_ADDR_HELD: assert property (s_wr_held |-> $stable(o_flash_addr))
		else $error("address moved inside a write pulse");
	AST_DATA_HELD: assert property (s_wr_held |-> $stable(o_flash_dq_o))
		else $error("data moved inside a write pulse");
	AST_WE_WIDTH: assert property ($fell(o_flash_we_n) |-> !o_flash_we_n [*8])
		else $error("write pulse too short");
	AST_POLL_ADDR: assert property (s_rd_held |-> $stable(o_flash_addr))
		else $error("address moved during a read");
	AST_OE_REST: assert property (
		$rose(o_flash_oe_n) && !o_flash_ce_n |-> o_flash_oe_n [*8])
		else $error("output gate high pulse too short");
	AST_TAKE: assert property (o_cmd_ready && i_cmd.valid |=> !o_cmd_ready)
		else $error("ready stayed up after a request");
	AST_DONE_PULSE: assert property (o_done |=> !o_done)
		else $error("done longer than one cycle");
endmodule : spfc_ctrl_asserts
bind spfc_ctrl spfc_ctrl_asserts spfc_ctrl_asserts_i (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd(i_cmd),
	.o_cmd_ready(o_cmd_ready), .o_done(o_done),
	.o_flash_ce_n(o_flash_ce_n), .o_flash_oe_n(o_flash_oe_n),
	.o_flash_we_n(o_flash_we_n), .o_flash_addr(o_flash_addr),
	.o_flash_dq_o(o_flash_dq_o), .o_flash_dq_oe(o_flash_dq_oe));

// *** verification/spfc_flash_model.sv ***
// Purpose: behavioural 64K x 8 sector flash with software protection
// Assumes: strobes seen on the bench clock, busy time counted in reads
// Notes:   i_hang keeps it busy forever to provoke the host timeout
`timescale 1ns/10ps
module spfc_flash_model
	import spfc_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
	parameter logic [7:0] PART_CODE  = 8'hC3, // arbitrary value
	parameter int unsigned BUSY_READS = 12
) (
	input  wire logic        i_clk,
	input  wire logic        i_hang,
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_din,
	output logic [7:0]       o_dq
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q = 8'h00, last_b = 8'h00;
	logic [1:0] seq = 2'h0;
	logic armed = 1'b0, id_mode = 1'b0, tog = 1'b0, wr_q = 1'b0, rd_q = 1'b0;
	int loads = 0, busy = 0;
	wire wr = !i_ce_n && !i_we_n && i_oe_n;
	wire rd = !i_ce_n && !i_oe_n;
	always @(posedge i_clk) begin
		wr_q <= wr;
		rd_q <= rd;
		if (wr && !wr_q && armed) begin
			mem[i_addr] = i_din; // bytes never loaded stay undefined
			last_b = i_din;
			loads++;
			if (loads == SECTOR_BYTES) begin
				busy = BUSY_READS;
				armed = 1'b0;
				loads = 0;
			end
		end else if (wr && !wr_q) begin // only A14..A0 decoded
			if (seq == 2'h0 && i_din == CMD_UNLOCK1_D
				&& i_addr[14:0] == CMD_UNLOCK1_A[14:0])
				seq = 2'h1;
			else if (seq == 2'h1 && i_din == CMD_UNLOCK2_D
				&& i_addr[14:0] == CMD_UNLOCK2_A[14:0])
				seq = 2'h2;
			else begin
				if (seq == 2'h2 && i_addr[14:0] == CMD_UNLOCK1_A[14:0]) begin
					armed = (i_din == CMD_PROT_D);
					if (i_din == CMD_ID_ENTRY_D) id_mode = 1'b1;
					if (i_din == CMD_ID_EXIT_D) id_mode = 1'b0;
				end
				seq = 2'h0;
			end
		end
		if (rd && !rd_q) begin
			if (busy > 0) begin
				tog = ~tog;
				last_q = {~last_b[7], tog, last_b[5:0]};
				if (!i_hang) busy--;
			end else if (id_mode)
				last_q = i_addr[0] ? PART_CODE : MAKER_CODE;
			else
				last_q = mem[i_addr];
		end
	end
	// a released bus shows the inverse so stale data cannot pass
	assign o_dq = rd ? last_q : ~last_q;
endmodule : spfc_flash_model

// *** verification/spfc_ctrl_tb.sv ***
// Purpose: self-checking bench for the sector flash controller
// Assumes: 50 MHz clock, short program timeout for simulation
// Notes:   sector byte n carries n xor 5a
`timescale 1ns/10ps
module spfc_ctrl_tb;
	import spfc_pkg::*;
	localparam logic [15:0] SEC = 16'h1280;
	logic i_core_clk = 1'b0, i_rst = 1'b1, hang = 1'b0;
	spfc_cmd_t i_cmd = '0;
	logic [7:0] widx = 8'h00, i_wdata, o_rdata, o_flash_dq_o, dq;
	logic [15:0] o_flash_addr;
	logic o_cmd_ready, o_wdata_req, o_done, o_timeout, ce_n, oe_n, we_n, dq_oe;
	int err_count = 0, checks_done = 0;
	always #10 i_core_clk = ~i_core_clk;
	assign i_wdata = widx ^ 8'h5A;
	always @(posedge i_core_clk) if (o_wdata_req === 1'b1) widx <= #1 widx + 8'h01;
	spfc_ctrl #(.PROG_TIMEOUT_CYC(2000)) spfc_ctrl_i (.i_core_clk(i_core_clk),
		.i_rst(i_rst), .i_cmd(i_cmd), .i_wdata(i_wdata),
		.o_cmd_ready(o_cmd_ready), .o_wdata_req(o_wdata_req), .o_done(o_done),
		.o_timeout(o_timeout), .o_rdata(o_rdata), .o_flash_ce_n(ce_n),
		.o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_addr(o_flash_addr),
		.o_flash_dq_o(o_flash_dq_o), .o_flash_dq_oe(dq_oe), .i_flash_dq_i(dq));
	spfc_flash_model spfc_flash_model_i (.i_clk(i_core_clk), .i_hang(hang),
		.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(o_flash_addr),
		.i_din(o_flash_dq_o), .o_dq(dq));
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	task automatic check(input string what, input logic [7:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic run_op(input logic [1:0] op, input logic [15:0] addr);
		int n;
		n = 0;
		i_cmd = '{1'b1, op, addr};
		while (o_cmd_ready !== 1'b1 && n < 100) begin
			@(posedge i_core_clk) #1;
			n++;
		end
		if (n >= 100) begin
			err_count++;
			$display("[FAIL] op %0d expected ready seen none", op);
			results();
		end
		@(posedge i_core_clk) #1;
		i_cmd.valid = 1'b0;
		while (o_done !== 1'b1 && n < 20000) begin
			@(posedge i_core_clk) #1;
			n++;
		end
		if (n >= 20000) begin
			err_count++;
			$display("[FAIL] op %0d expected done seen none", op);
			results();
		end
	endtask : run_op
	localparam logic [15:0] SEC_OFS [3] = '{16'h0000, 16'h0001, 16'h007F};
	task automatic t_program;
		widx = 8'h00;
		run_op(OP_PROGRAM, SEC | 16'h0005);
		check("timeout", 8'h00, {7'h00, o_timeout});
		check("loads", 8'h80, widx);
		foreach (SEC_OFS[i]) begin
			run_op(OP_READ, SEC + SEC_OFS[i]);
			check("sector byte", SEC_OFS[i][7:0] ^ 8'h5A, o_rdata);
		end
	endtask : t_program
	task automatic t_ident;
		run_op(OP_ID_READ, 16'h0000);
		check("maker code", 8'hA5, o_rdata);
		run_op(OP_ID_READ, 16'h0001);
		check("part code", 8'hC3, o_rdata);
		run_op(OP_READ, SEC + 16'h0002);
		check("array after exit", 8'h58, o_rdata);
	endtask : t_ident
	task automatic t_timeout;
		hang = 1'b1;
		widx = 8'h00;
		run_op(OP_PROGRAM, SEC);
		check("timeout", 8'h01, {7'h00, o_timeout});
		hang = 1'b0;
		i_rst = 1'b1;
		@(posedge i_core_clk) #1;
		check("ready in reset", 8'h00, {7'h00, o_cmd_ready});
		check("strobes in reset", 8'h07, {5'h00, ce_n, oe_n, we_n});
		i_rst = 1'b0;
		@(posedge i_core_clk) #1;
		check("ready after reset", 8'h01, {7'h00, o_cmd_ready});
	endtask : t_timeout
	initial begin
		repeat (8) @(posedge i_core_clk);
		#1 i_rst = 1'b0;
		t_program();
		t_ident();
		t_timeout();
		results();
	end
endmodule : spfc_ctrl_tb
